// ### design/dual_adc_pkg.sv
// Shared constants and carrier types for the dual converter serial readout
package dual_adc_pkg;
  localparam int RESULT_BITS    = 14;
  localparam int LEAD_ZEROS     = 2;
  localparam int WORD_EDGES     = 16;
  localparam int SLOT_EDGES     = 18;
  localparam int CHAIN_EDGES    = 36;
  localparam int EDGE_CNT_W     = 6;
  localparam int FIFO_DEPTH     = 8;
  localparam int FIFO_W         = 2 * RESULT_BITS;
  localparam logic [5:0] CONV_DONE_EDGE = 6'h10;
  localparam logic [5:0] SLOT_LAST_EDGE = 6'h11;
  localparam logic [5:0] CHAIN_LAST_EDGE = 6'h23;

  typedef struct packed {
    logic [RESULT_BITS-1:0] codeA;
    logic [RESULT_BITS-1:0] codeB;
  } sample_pair_type;
endpackage

// ### design/sample_fifo.sv
// Parameterised valid/ready FIFO holding sample pairs
module sample_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      nextCount;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  // Occupancy after this edge; ready is registered from it so it leaves a flop
  assign nextCount = count + (AW+1)'(doWrite) - (AW+1)'(doRead);
  assign outValid  = (count != '0);
  assign outData  = mem[rdPtr];

  // Storage write
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count   <= '0;
      inReady <= 1'b1;
    end else begin
      if (doWrite) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (doRead)  rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      count   <= nextCount;
      inReady <= (nextCount != (AW+1)'(DEPTH));
    end
  end
endmodule

// ### design/dual_adc_serial_readout.sv
// Serial readout and conversion start of a dual 14-bit sampling converter
module dual_adc_serial_readout (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire dual_adc_pkg::sample_pair_type     sampleIn,
  input  wire logic                              sampleValid,
  output logic                                   sampleReady,
  input  wire logic                              serialClk,
  input  wire logic                              frameSelectN,
  output logic                                   result_out_a,
  output logic                                   result_out_b,
  output logic                                   trackA,
  output logic                                   trackB
);
  localparam int RB = dual_adc_pkg::RESULT_BITS;

  // Main domain: FIFO of digitised codes awaiting a conversion
  dual_adc_pkg::sample_pair_type fifoOut;
  logic                          fifoValid;
  logic                          fifoTake;

  sample_fifo #(
    .WIDTH (dual_adc_pkg::FIFO_W),
    .DEPTH (dual_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (mclk),
    .rst      (sys_rst),
    .inData   (sampleIn),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoTake)
  );

  // Handshake: main offers a word, link toggles ack when it latched it
  dual_adc_pkg::sample_pair_type offerWord;
  logic offerFull;
  logic offerToggle;
  logic ackToggleLink;
  logic ackSync1;
  logic ackSync2;
  logic ackSeen;
  wire  ackEvent = (ackSync2 != ackSeen);

  assign fifoTake = fifoValid && !offerFull;

  // Keep one word parked for the next conversion; refill after each use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      offerWord   <= '0;
      offerFull   <= 1'b0;
      offerToggle <= 1'b0;
      ackSync1    <= 1'b0;
      ackSync2    <= 1'b0;
      ackSeen     <= 1'b0;
    end else begin
      ackSync1 <= ackToggleLink;
      ackSync2 <= ackSync1;
      ackSeen  <= ackSync2;
      if (fifoTake) begin
        offerWord   <= fifoOut;
        offerFull   <= 1'b1;
        offerToggle <= ~offerToggle;
      end else if (ackEvent) begin
        offerFull <= 1'b0;
      end
    end
  end

  // Link domain: request toggle synchronised into serial clock
  logic offSync1;
  logic offSync2;
  logic offUsed;
  wire  freshWord = (offSync2 != offUsed);

  // Frame edge counter, falling edges of serial clock
  logic [dual_adc_pkg::EDGE_CNT_W-1:0] edgeCnt;
  logic                                inFrame;
  logic [RB-1:0]                       sarA;
  logic [RB-1:0]                       sarB;
  logic [RB-1:0]                       heldA;
  logic [RB-1:0]                       heldB;
  logic [RB-1:0]                       resA;
  logic [RB-1:0]                       resB;
  logic                                converting;

  // Slot bit selection: zeros, MSB-first code, trailing zeros
  logic [dual_adc_pkg::EDGE_CNT_W-1:0] slotPos;
  logic                                secondSlot;
  logic                                bitA;
  logic                                bitB;
  logic [3:0]                          codeIdx;
  assign secondSlot = (edgeCnt > dual_adc_pkg::SLOT_LAST_EDGE);
  assign slotPos    = secondSlot ? edgeCnt - 6'(dual_adc_pkg::SLOT_EDGES) : edgeCnt;
  assign codeIdx    = 4'(RB + dual_adc_pkg::LEAD_ZEROS - 1 - 32'(slotPos));
  wire   codeBit    = (slotPos >= 6'(dual_adc_pkg::LEAD_ZEROS)) &&
                      (slotPos < 6'(dual_adc_pkg::WORD_EDGES));
  assign bitA = codeBit && (secondSlot ? resB[codeIdx] : resA[codeIdx]);
  assign bitB = codeBit && (secondSlot ? resA[codeIdx] : resB[codeIdx]);

  // Capture the parked word at frame start; frame resets on deassert
  always_ff @(negedge serialClk or posedge frameSelectN) begin
    if (frameSelectN) begin
      edgeCnt    <= '0;
      inFrame    <= 1'b0;
      converting <= 1'b0;
    end else begin
      inFrame <= 1'b1;
      if (!inFrame) begin
        converting <= 1'b1;
        edgeCnt    <= 6'h01;
      end else begin
        if (edgeCnt != dual_adc_pkg::CHAIN_LAST_EDGE + 6'h01) begin
          edgeCnt <= edgeCnt + 6'h01;
        end
        if (edgeCnt == dual_adc_pkg::CONV_DONE_EDGE - 6'h01) begin
          converting <= 1'b0;
        end
      end
    end
  end

  // Link reset: asserted at once, released on serial falls to avoid a runt
  logic linkRstMeta;
  logic linkRst;
  wire  frameStart = !frameSelectN && !inFrame;

  always_ff @(negedge serialClk or posedge sys_rst) begin
    if (sys_rst) begin
      linkRstMeta <= 1'b1;
      linkRst     <= 1'b1;
    end else begin
      linkRstMeta <= 1'b0;
      linkRst     <= linkRstMeta;
    end
  end

  // Handshake flops survive frames, so only the system reset clears them
  always_ff @(negedge serialClk or posedge linkRst) begin
    if (linkRst) begin
      offSync1      <= 1'b0;
      offSync2      <= 1'b0;
      offUsed       <= 1'b0;
      ackToggleLink <= 1'b0;
    end else begin
      offSync1 <= offerToggle;
      offSync2 <= offSync1;
      if (frameStart && freshWord) begin
        offUsed       <= offSync2;
        ackToggleLink <= ~ackToggleLink;
      end
    end
  end

  // Serial clock paces the successive approximation, one bit per edge
  always_ff @(negedge serialClk) begin
    if (frameStart) begin
      heldA <= freshWord ? offerWord.codeA : '0;
      heldB <= freshWord ? offerWord.codeB : '0;
      sarA  <= '0;
      sarB  <= '0;
    end else if (converting && edgeCnt >= 6'(dual_adc_pkg::LEAD_ZEROS)) begin
      sarA[codeIdx] <= heldA[codeIdx];
      sarB[codeIdx] <= heldB[codeIdx];
    end
  end

  // Bit being resolved on this edge is bypassed, else it would leave late
  logic [RB-1:0] resolveMask;
  assign resolveMask = (RB'(1) << codeIdx) & {RB{converting}};
  assign resA = sarA | (heldA & resolveMask);
  assign resB = sarB | (heldB & resolveMask);

  // Outputs change on falling edges or frame deassert; data lines low and track high outside the frame
  always_ff @(negedge serialClk or posedge frameSelectN) begin
    if (frameSelectN) begin
      result_out_a <= 1'b0;
      result_out_b <= 1'b0;
      trackA       <= 1'b1;
      trackB       <= 1'b1;
    end else begin
      result_out_a <= inFrame ? bitA : 1'b0;
      result_out_b <= inFrame ? bitB : 1'b0;
      trackA       <= inFrame && !converting;
      trackB       <= inFrame && !converting;
    end
  end
endmodule

// ### testbench/adc_readout_monitor.sv
// Checker of framing, bit order and track timing at the readout ports
module adc_readout_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic frameSelectN,
  input wire logic result_out_a,
  input wire logic result_out_b,
  input wire logic trackA,
  input wire logic trackB
);
  logic [5:0] edgeCnt;

  // Falls seen in this frame; frame high clears it like the link logic
  always_ff @(negedge serialClk or posedge frameSelectN) begin
    if (frameSelectN)
      edgeCnt <= 6'h0;
    else if (edgeCnt != 6'h3f)
      edgeCnt <= edgeCnt + 6'h1;
  end

  // Two samples so an abort edge is not judged mid-clear
  sequence frameIdle;
    frameSelectN && $past(frameSelectN);
  endsequence

  idle_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frameIdle |-> !result_out_a && !result_out_b) else $error("line high outside frame");
  idle_track_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frameIdle |-> trackA && trackB) else $error("hold outside frame");
  stable_fall_a: assert property (@(posedge mclk) disable iff (sys_rst)
    serialClk && $past(serialClk) && !frameSelectN |->
    $stable(result_out_a) && $stable(result_out_b)) else $error("bit moved off falling edge");
  lead_zero_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt inside {6'h1, 6'h2} |-> !result_out_a && !result_out_b) else $error("lead bit high");
  trail_zero_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt inside {6'h11, 6'h12, 6'h23} |-> !result_out_a && !result_out_b)
    else $error("trail bit high");
  hold_conv_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt inside {[6'h1:6'hf]} |-> !trackA && !trackB) else $error("track during conversion");
  track_back_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt == 6'h11 |-> trackA && trackB) else $error("no track after conversion");
  chain_ab_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt inside {[6'h15:6'h22]} |-> result_out_a == $past(result_out_b, 18))
    else $error("line a chain wrong");
  chain_ba_a: assert property (@(negedge serialClk) disable iff (frameSelectN)
    edgeCnt inside {[6'h15:6'h22]} |-> result_out_b == $past(result_out_a, 18))
    else $error("line b chain wrong");
endmodule

bind dual_adc_serial_readout adc_readout_monitor u_adc_readout_monitor (.*);

// ### testbench/host_serial_model.sv
// Host side model: frames a transfer and samples both data lines
module host_serial_model (
  output logic      serialClk,
  output logic      frameSelectN,
  input  wire logic result_out_a,
  input  wire logic result_out_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] capA;
  logic [35:0] capB;

  // Clock runs free so the word handshake can cross between frames
  initial begin
    serialClk = 1'h1;
    frameSelectN = 1'h1;
  end

  always #32 serialClk = ~serialClk;

  // Sample on rising edges, mid bit; a short count aborts the readout
  task automatic run_frame(input int edges);
    repeat (4) @(posedge serialClk);
    frameSelectN = 1'h0;
    for (int i = 0; i < edges; i++) begin
      @(negedge serialClk);
      @(posedge serialClk);
      capA = {capA[34:0], result_out_a};
      capB = {capB[34:0], result_out_b};
    end
    frameSelectN = 1'h1;
  endtask
endmodule

// ### testbench/tb_dual_adc_serial_readout.sv
// Self-checking bench for the dual converter serial readout
module tb_dual_adc_serial_readout;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic sampleValid = 1'h0;
  logic sampleReady, serialClk, frameSelectN, result_out_a, result_out_b, trackA, trackB;
  dual_adc_pkg::sample_pair_type sampleIn = '0;
  int miscompares = 0;
  int cmp_count = 0;

  // System clock
  always #10 mclk = ~mclk;

  dual_adc_serial_readout u_dual_adc_serial_readout (.*);
  host_serial_model u_host_serial_model (.*);

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offer one pair; valid held until ready is seen
  task automatic push(input logic [13:0] a, input logic [13:0] b);
    int n = 0;
    @(posedge mclk);
    #1 sampleIn = {a, b};
    sampleValid = 1'h1;
    while (sampleReady !== 1'h1 && n < 50) begin
      @(posedge mclk);
      #1 n++;
    end
    @(posedge mclk);
    #1 sampleValid = 1'h0;
  endtask

  // Fill until refused (parked word plus eight), then drain; first frame chains
  task automatic fill_drain();
    logic [13:0] a;
    logic [13:0] b;
    for (int i = 0; i < 9; i++) push(14'h3fff - 14'(i), 14'(i));
    chk(36'(sampleReady), 36'h0);
    for (int i = 0; i < 9; i++) begin
      a = 14'h3fff - 14'(i);
      b = 14'(i);
      u_host_serial_model.run_frame(i == 0 ? 36 : 16);
      if (i == 0) begin
        chk(u_host_serial_model.capA, {2'h0, a, 4'h0, b, 2'h0});
        chk(u_host_serial_model.capB, {2'h0, b, 4'h0, a, 2'h0});
      end else begin
        chk(u_host_serial_model.capA & 36'hffff, 36'(a));
        chk(u_host_serial_model.capB & 36'hffff, 36'(b));
      end
    end
    $display("fill_drain done");
  endtask

  // Aborted frame, then a fresh frame converts the next pair
  task automatic abort_restart();
    push(14'h1234, 14'h0abc);
    u_host_serial_model.run_frame(8);
    chk(u_host_serial_model.capA & 36'hff, 36'h12);
    chk(u_host_serial_model.capB & 36'hff, 36'h0a);
    push(14'h0f0f, 14'h30f0);
    u_host_serial_model.run_frame(16);
    chk(u_host_serial_model.capA & 36'hffff, 36'h0f0f);
    chk(u_host_serial_model.capB & 36'hffff, 36'h30f0);
    $display("abort_restart done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'h0;
    fill_drain();
    abort_restart();
    complete_run();
  end

  // Watchdog, well beyond the eleven frames needed
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
